/* verilog/pts_pkg.sv */
// package: register map, field layout and constants of the period timer
`default_nettype none
package pts_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CONTROL  = 8'h00;
	localparam logic [7:0] ADDR_COUNT    = 8'h04;
	localparam logic [7:0] ADDR_PERIOD   = 8'h08;
	localparam logic [7:0] ADDR_STATUS   = 8'h0C;
	localparam logic [7:0] ADDR_CLEAR    = 8'h10;
	localparam logic [7:0] ADDR_ENABLE   = 8'h14;
	// control field layout
	localparam int PRE_LSB  = 0;
	localparam int RUN_BIT  = 2;
	localparam int POST_LSB = 3;
	localparam int POST_MSB = 6;
	localparam logic [7:0] CONTROL_MASK  = 8'h7F;
	// reset values
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] COUNT_RESET   = 8'h00;
	localparam logic [7:0] PERIOD_RESET  = 8'hFF;
	// prescale terminal counts (ratio minus one)
	localparam logic [3:0] PRE_TERM_1    = 4'h0;
	localparam logic [3:0] PRE_TERM_4    = 4'h3;
	localparam logic [3:0] PRE_TERM_16   = 4'hF;
	// instruction clock is the core clock divided by four
	localparam logic [1:0] INSTR_DIV_TERM = 2'h3;
	// status bit of the period flag
	localparam int FLAG_BIT = 0;
endpackage : pts_pkg
`default_nettype wire

/* verilog/pts_timer.sv */
// period timer with prescaler, postscaler and apb register slave
//
// Our own choices: the placing of the registers and register access over APB.
`default_nettype none
module pts_timer #(
	parameter int ADDR_WIDTH = 8
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [ADDR_WIDTH-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	output logic                       irq
);

	// only paddr[7:0] is decoded, so a narrower bus cannot reach the map
	if (ADDR_WIDTH < 8) begin : addr_width_check
		$error("ADDR_WIDTH below the eight decoded address bits");
	end

	logic [7:0] timer_control;
	logic [7:0] tick_count;
	logic [7:0] period_value;
	logic [0:0] peripheral_flags;
	logic [0:0] flag_enable;
	logic [1:0] instr_div;
	logic [3:0] pre_count;
	logic [3:0] post_count;
	logic       access;
	logic       wr_en;
	logic       rd_en;
	logic       hit_ctl;
	logic       hit_cnt;
	logic       hit_per;
	logic       hit_sts;
	logic       hit_clr;
	logic       hit_ena;
	logic       mapped;
	logic       instr_tick;
	logic       pre_tick;
	logic       match;
	logic       count_step;
	logic       post_tick;
	logic       scaler_clear;
	logic       timer_run;
	logic [1:0] prescale_select;
	logic [3:0] postscale_select;
	logic [3:0] pre_term;
	logic [7:0] next_count;
	logic       flag_clr;
	logic       ena_wr;

	////////////////////////////////////////////////////////////////////////////
	// apb decode; slave answers in the first access cycle, no wait states
	assign access  = psel && penable;
	assign wr_en   = access && pwrite && pstrb[0];
	// read data is fetched at the setup edge so it stands beside pready
	assign rd_en   = psel && !penable && !pwrite;
	assign hit_ctl = (paddr[7:0] == pts_pkg::ADDR_CONTROL);
	assign hit_cnt = (paddr[7:0] == pts_pkg::ADDR_COUNT);
	assign hit_per = (paddr[7:0] == pts_pkg::ADDR_PERIOD);
	assign hit_sts = (paddr[7:0] == pts_pkg::ADDR_STATUS);
	assign hit_clr = (paddr[7:0] == pts_pkg::ADDR_CLEAR);
	assign hit_ena = (paddr[7:0] == pts_pkg::ADDR_ENABLE);
	assign mapped  = hit_ctl || hit_cnt || hit_per || hit_sts || hit_clr || hit_ena;

	// control fields
	assign timer_run        = timer_control[pts_pkg::RUN_BIT];
	assign prescale_select  = timer_control[pts_pkg::PRE_LSB +: 2];
	assign postscale_select = timer_control[pts_pkg::POST_MSB:pts_pkg::POST_LSB];

	// prescale ratio; upper bit set means sixteen regardless of the lower
	always_comb begin
		case (prescale_select)
			2'h0:    pre_term = pts_pkg::PRE_TERM_1;
			2'h1:    pre_term = pts_pkg::PRE_TERM_4;
			default: pre_term = pts_pkg::PRE_TERM_16;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// tick chain: instruction enable, prescaler, match, postscaler
	assign scaler_clear = wr_en && (hit_cnt || hit_ctl);
	assign instr_tick   = (instr_div == pts_pkg::INSTR_DIV_TERM);
	assign pre_tick     = timer_run && instr_tick && (pre_count == pre_term)
		&& !scaler_clear;
	assign match        = (tick_count == period_value);
	assign count_step   = pre_tick && !(wr_en && hit_cnt);
	assign post_tick    = count_step && match && (post_count == postscale_select);
	assign next_count   = match ? pts_pkg::COUNT_RESET : 8'(tick_count + 8'h01);

	// free-running divide by four of the core clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			instr_div <= 2'h0;
		else
			instr_div <= 2'(instr_div + 2'h1);
	end

	// prescaler counter; stops with the run bit, but the control write that restarts it also clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_count <= 4'h0;
		end else if (scaler_clear) begin
			pre_count <= 4'h0;
		end else if (timer_run && instr_tick) begin
			if (pre_count >= pre_term)
				pre_count <= 4'h0;
			else
				pre_count <= 4'(pre_count + 4'h1);
		end
	end

	// postscaler counter, advanced once per match
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			post_count <= 4'h0;
		end else if (scaler_clear) begin
			post_count <= 4'h0;
		end else if (count_step && match) begin
			if (post_count >= postscale_select)
				post_count <= 4'h0;
			else
				post_count <= 4'(post_count + 4'h1);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers written by software
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_control <= pts_pkg::CONTROL_RESET;
		end else if (wr_en && hit_ctl) begin
			timer_control <= pwdata[7:0] & pts_pkg::CONTROL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_value <= pts_pkg::PERIOD_RESET;
		end else if (wr_en && hit_per) begin
			period_value <= pwdata[7:0];
		end
	end

	// count: software write beats an increment in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_count <= pts_pkg::COUNT_RESET;
		end else if (wr_en && hit_cnt) begin
			tick_count <= pwdata[7:0];
		end else if (count_step) begin
			tick_count <= next_count;
		end
		// a control write falls through here untouched
	end

	////////////////////////////////////////////////////////////////////////////
	// clear strobe and mask write, shared by the flag, mask and line
	assign flag_clr = wr_en && hit_clr && pwdata[pts_pkg::FLAG_BIT];
	assign ena_wr   = wr_en && hit_ena;

	// sticky flag; a new event wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			peripheral_flags <= 1'h0;
		end else if (post_tick) begin
			peripheral_flags <= 1'h1;
		end else if (flag_clr) begin
			peripheral_flags <= 1'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			flag_enable <= 1'h0;
		else if (ena_wr)
			flag_enable <= pwdata[pts_pkg::FLAG_BIT +: 1];
	end

	// level interrupt from a flop; it is fed the values that flag and mask
	// take at this edge, so it never lags a clear or a mask write by a cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= (post_tick || (peripheral_flags[0] && !flag_clr))
				&& (ena_wr ? pwdata[pts_pkg::FLAG_BIT] : flag_enable[0]);
	end

	////////////////////////////////////////////////////////////////////////////
	// read data and answer; unmapped addresses get pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= 32'h0000_0000;
			if (hit_ctl)
				prdata[7:0] <= timer_control;
			else if (hit_cnt)
				prdata[7:0] <= tick_count;
			else if (hit_per)
				prdata[7:0] <= period_value;
			else if (hit_sts)
				prdata[0] <= peripheral_flags[0];
			else if (hit_ena)
				prdata[0] <= flag_enable[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks; a break in the tick chain shows here before it shows on the bus

	// count movement
	run_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!timer_run && !(wr_en && hit_cnt) |=> tick_count == $past(tick_count))
		else $error("count moved while stopped");

	wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		count_step && match |=> tick_count == 8'h00)
		else $error("count did not wrap to zero after match");

	step_up_a: assert property (@(posedge pclk) disable iff (!presetn)
		count_step && !match |=> tick_count == 8'($past(tick_count) + 8'h01))
		else $error("count did not advance by one");

	stop_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!timer_run |-> !count_step && !post_tick)
		else $error("tick chain active while stopped");

	// prescaler and instruction rate
	div_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		timer_run && prescale_select == 2'h0 && instr_tick && !scaler_clear
		&& !(wr_en && hit_cnt) |-> count_step)
		else $error("prescale one missed an instruction tick");

	instr_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
		pre_tick |=> !pre_tick [*3])
		else $error("count advanced faster than instruction clock");

	instr_only_a: assert property (@(posedge pclk) disable iff (!presetn)
		count_step |-> instr_tick)
		else $error("count advanced off an instruction tick");

	pre_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		pre_count <= pre_term)
		else $error("prescaler ran past its ratio");

	pre_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		!timer_run && !scaler_clear |=> pre_count == $past(pre_count))
		else $error("prescaler moved while stopped");

	// postscaler, scaler clearing and flag
	post_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		post_count <= postscale_select)
		else $error("postscaler ran past its ratio");

	scaler_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
		scaler_clear |=> pre_count == 4'h0 && post_count == 4'h0)
		else $error("scaler counters not cleared by write");

	flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		post_tick |=> peripheral_flags[0])
		else $error("postscaler output did not set flag");

	flag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		flag_clr && !post_tick |=> !peripheral_flags[0])
		else $error("flag clear lost");

	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		irq == (peripheral_flags[0] && flag_enable[0]))
		else $error("interrupt line disagrees with flag and mask");

	// registers and bus
	ctl_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_ctl |=> tick_count == $past(tick_count))
		else $error("control write changed the count");

	bit7_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		timer_control[7] == 1'b0)
		else $error("unimplemented control bit set");

	ctl_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_ctl |=> timer_control == ($past(pwdata[7:0]) & pts_pkg::CONTROL_MASK))
		else $error("control write lost");

	period_rst_a: assert property (@(posedge pclk)
		$rose(presetn) |-> period_value == pts_pkg::PERIOD_RESET
		&& tick_count == pts_pkg::COUNT_RESET)
		else $error("reset values wrong");

	period_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_per |=> period_value == $past(pwdata[7:0]))
		else $error("period write lost");

	count_wr_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit_cnt |=> tick_count == $past(pwdata[7:0]))
		else $error("count write lost");

	count_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
		rd_en && hit_cnt |=> prdata[7:0] == $past(tick_count))
		else $error("count read returned a stale value");

	ready_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable |=> pready)
		else $error("setup cycle not answered");

	err_map_a: assert property (@(posedge pclk) disable iff (!presetn)
		psel && !penable && !mapped |=> pslverr && pready)
		else $error("unmapped access not refused");

endmodule : pts_timer
`default_nettype wire

/* tb/pts_timer_bench.sv */
// self-checking bench of the period timer, driven over its apb port
`default_nettype none
module pts_timer_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic [3:0]  pstrb;
	logic        pready;
	logic        pslverr;
	logic        irq;
	logic        err;
	int          fail_count;
	int          check_count;
	int          cyc;
	int          t0;
	int          t1;

	pts_timer #(.ADDR_WIDTH(8)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
	);

	// 125 MHz clock and a free cycle count for interval measurement
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;

	////////////////////////////////////////////////////////////////////////////////
	// verdict, comparison and bus tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			fail_count++;
			$display("[FAIL] pready expected 1 seen 0");
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask

	// waits for the interrupt line, then clears the flag; t is the rise cycle
	task automatic irq_clear(output int t);
		int n;
		for (n = 0; n < 3000; n++) begin
			@(posedge pclk);
			if (irq === 1'b1) break;
		end
		if (n == 3000) begin
			fail_count++;
			$display("[FAIL] irq expected 1 seen 0");
			tally_and_finish();
		end
		t = cyc;
		xfer(1'b1, pts_pkg::ADDR_CLEAR, 32'h1);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// main sequence
	logic [1:0] pre_t [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
	int         post_t [4] = '{0, 1, 15, 2};
	int         per_t [4] = '{3, 2, 0, 1};
	int         mx;
	int         div;
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		fail_count = 0;
		check_count = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and the unimplemented control bit
		rchk("control reset", pts_pkg::ADDR_CONTROL, 32'h00);
		rchk("count reset", pts_pkg::ADDR_COUNT, 32'h00);
		rchk("period reset", pts_pkg::ADDR_PERIOD, 32'hFF);
		xfer(1'b1, pts_pkg::ADDR_CONTROL, 32'hFB);
		rchk("control bit7", pts_pkg::ADDR_CONTROL, 32'h7B);
		xfer(1'b0, 8'h18, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		$display("test reset and map done");
		// stopped timer holds its count and raises nothing
		xfer(1'b1, pts_pkg::ADDR_CONTROL, 32'h00);
		xfer(1'b1, pts_pkg::ADDR_PERIOD, 32'h05);
		rchk("period rw", pts_pkg::ADDR_PERIOD, 32'h05);
		// a write with the low byte strobe off must be ignored
		pstrb <= 4'h0;
		xfer(1'b1, pts_pkg::ADDR_PERIOD, 32'h22);
		pstrb <= 4'hF;
		rchk("period strobe off", pts_pkg::ADDR_PERIOD, 32'h05);
		xfer(1'b1, pts_pkg::ADDR_COUNT, 32'h03);
		xfer(1'b1, pts_pkg::ADDR_CLEAR, 32'h1);
		repeat (100) @(posedge pclk);
		rchk("count held", pts_pkg::ADDR_COUNT, 32'h03);
		rchk("no flag stopped", pts_pkg::ADDR_STATUS, 32'h0);
		$display("test stopped done");
		// count runs 0..period and wraps; every value is sampled
		xfer(1'b1, pts_pkg::ADDR_COUNT, 32'h00);
		xfer(1'b1, pts_pkg::ADDR_CONTROL, 32'h04);
		mx = 0;
		repeat (30) begin
			xfer(1'b0, pts_pkg::ADDR_COUNT, 32'h0);
			if (rd > mx) mx = rd;
		end
		chk("count ceiling", 32'h05, 32'(mx));
		$display("test wrap done");
		// scaler writes: repeated writes keep the prescaler from ever expiring
		xfer(1'b1, pts_pkg::ADDR_CONTROL, 32'h06);
		xfer(1'b1, pts_pkg::ADDR_COUNT, 32'h10);
		repeat (6) begin
			xfer(1'b1, pts_pkg::ADDR_CONTROL, 32'h06);
			repeat (20) @(posedge pclk);
			rchk("count after ctrl", pts_pkg::ADDR_COUNT, 32'h10);
		end
		$display("test scaler clear done");
		// flag interval for every prescale code with assorted postscales
		xfer(1'b1, pts_pkg::ADDR_ENABLE, 32'h1);
		rchk("enable rw", pts_pkg::ADDR_ENABLE, 32'h1);
		for (int i = 0; i < 4; i++) begin
			div = (pre_t[i] == 2'h0) ? 1 : (pre_t[i] == 2'h1) ? 4 : 16;
			xfer(1'b1, pts_pkg::ADDR_CONTROL, 32'h00);
			xfer(1'b1, pts_pkg::ADDR_PERIOD, 32'(per_t[i]));
			xfer(1'b1, pts_pkg::ADDR_COUNT, 32'h00);
			xfer(1'b1, pts_pkg::ADDR_CONTROL, 32'(post_t[i] * 8 + 4 + pre_t[i]));
			irq_clear(t0);
			irq_clear(t0);
			irq_clear(t1);
			chk("flag interval", 32'((per_t[i] + 1) * (post_t[i] + 1) * 4 * div),
				32'(t1 - t0));
		end
		$display("test scalers done");
		// masked flag still sets, line stays low; clear empties it
		xfer(1'b1, pts_pkg::ADDR_ENABLE, 32'h0);
		rd = 32'h0;
		for (int n = 0; n < 300 && rd[0] !== 1'b1; n++) xfer(1'b0, pts_pkg::ADDR_STATUS, 32'h0);
		chk("masked flag", 32'h1, rd);
		chk("masked irq", 32'h0, {31'h0, irq});
		xfer(1'b1, pts_pkg::ADDR_CONTROL, 32'h00);
		xfer(1'b1, pts_pkg::ADDR_CLEAR, 32'h1);
		rchk("flag cleared", pts_pkg::ADDR_STATUS, 32'h0);
		$display("test interrupt mask done");
		tally_and_finish();
	end
endmodule // pts_timer_bench
`default_nettype wire
